// ===== pgm_host_model.sv
/*
 Pad-side model of the far party: the external bus device or dual-port host.
 Assumes the port drives its pads from registers clocked by sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pgm_host_model (
   input wire logic sys_clk,
   input wire logic [7:0] padOut,
   input wire logic [7:0] padOe,
   input wire logic [7:0] padPullup,
   input wire logic [7:0] hostOe,
   input wire logic [7:0] hostData,
   output logic [7:0] padIn
);
   // ---------------------------------------------------------------
   // Wire resolution
   // ---------------------------------------------------------------
   logic [7:0] floatPat_q = 8'h5a;
   // Undriven pins toggle, so a missing pull-up never reads as a steady level
   always_ff @(posedge sys_clk) begin
      floatPat_q <= ~floatPat_q;
   end
   // Port drive first, then host, then pull-up, else the floating pattern
   always_comb begin
      padIn = (padOe & padOut) | (~padOe & hostOe & hostData)
         | (~padOe & ~hostOe & (padPullup | floatPat_q));
   end
endmodule
`default_nettype wire

// ===== pgm_pin_cell.sv
/*
 One pin cell: output enable and pull-up decision for a single pin.
 Assumes pin function and standby states are decoded by the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module pgm_pin_cell
   import pgm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire pgm_pkg::pgm_pinfn_t pinFn,
   input wire logic holdOff,
   input wire logic dirBit,
   input wire logic pullBit,
   input wire logic busOe,
   input wire logic busOut,
   input wire logic latchBit,
   output logic pinOe_q,
   output logic pinOut_q,
   output logic pinPull_q
);
   import pgm_pkg::*;

   // ---------------------------------------------------------------
   // Registered pin drive
   // ---------------------------------------------------------------
   // Outputs registered so the pad sees no decode glitches
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pinOe_q <= 1'b0;
         pinOut_q <= 1'b0;
      end else begin
         unique case (pinFn)
            PFN_EXT_BUS, PFN_DPRAM: begin
               pinOe_q <= busOe && !holdOff; // RULE2 RULE3 RULE6 RULE7
               pinOut_q <= busOut;
            end
            PFN_GPIO: begin
               pinOe_q <= dirBit; // RULE4
               pinOut_q <= latchBit;
            end
            default: begin
               pinOe_q <= 1'b0;
               pinOut_q <= 1'b0;
            end
         endcase
      end
   end

   // Pull-up only for an input pin in plain GPIO use
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pinPull_q <= 1'b0;
      end else begin
         pinPull_q <= (pinFn == PFN_GPIO) && !dirBit && pullBit; // RULE11 RULE13
      end
   end
endmodule
`default_nettype wire

// ===== pgm_pkg.sv
/*
 Package for the pin port block: register indices, field widths, reset values
 and the operating mode encoding.
 Assumes a Wishbone classic slave with 32-bit data, one register per word.
*/
package pgm_pkg;
   // ---------------------------------------------------------------
   // Register map (printed offsets are indices, byte address is 4x)
   // ---------------------------------------------------------------
   localparam int PORT_W = 8;
   localparam int ADDR_W = 18;
   localparam logic [15:0] IDX_PULLUP = 16'hffae;
   localparam logic [15:0] IDX_DIR = 16'hffb4;
   localparam logic [15:0] IDX_LATCH = 16'hffb6;
   localparam logic [7:0] RST_PULLUP = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] DIR_READ_VAL = 8'hff;
   localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
   // ---------------------------------------------------------------
   // Operating modes
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_EXP1 = 2'h1;
   localparam logic [1:0] MODE_EXP2 = 2'h2;
   localparam logic [1:0] MODE_SINGLE = 2'h3;
   // Pin function selected by mode and slave enable
   typedef enum logic [1:0] {PFN_EXT_BUS, PFN_GPIO, PFN_DPRAM} pgm_pinfn_t;
endpackage

// ===== pgm_port3.sv
/*
 Top of the 8-bit shared pin port: Wishbone register slave, mode decode and
 one pin cell per pin.
 Assumes mode, slave enable and standby levels come from system control,
 and that pin inputs are synchronous to sys_clk.
*/
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE1] Direction register is write-only; reads return all ones.
// [RULE2] Modes 1 and 2 ignore direction; pins are the external data bus.
// [RULE3] External data bus floats in reset, hardware and software standby.
// [RULE4] Mode 3 without slave: direction 1 drives latch, 0 is input.
// [RULE5] Direction clears on reset and hardware standby, holds in software standby.
// [RULE6] Slave enable in mode 3 clears direction and gives pins to dual-port bus.
// [RULE7] Dual-port bus floats during software standby.
// [RULE8] Reset or hardware standby clears slave enable and direction.
// [RULE9] Data read gives latch for outputs, pin level for inputs.
// [RULE10] Output latch clears on reset and hardware standby, holds in software standby.
// [RULE11] Mode 3 GPIO pull-up on exactly when direction 0 and pull bit 1.
// [RULE12] Pull-up register clears on reset and hardware standby, holds otherwise.
// [RULE13] Pull-ups off in modes 1, 2, slave mode, reset and hardware standby.
// [RULE14] Software should clear the latch when choosing slave mode.
// [RULE15] Software clears slave enable and direction before setting a pull bit.
// [RULE16] Mode, slave enable and standby states are inputs from system control.
module pgm_port3
   import pgm_pkg::*;
#(
   parameter int WIDTH = PORT_W
)
(
   input wire logic sys_clk,
   input wire logic rstn,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pgm_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // System control levels
   input wire logic [1:0] opMode,
   input wire logic dualPortSlaveEnable,
   input wire logic hwStandby,
   input wire logic swStandby,
   // External data bus and dual-port bus sources
   input wire logic extBusOe,
   input wire logic [WIDTH-1:0] extBusOut,
   input wire logic dpBusOe,
   input wire logic [WIDTH-1:0] dpBusOut,
   output logic [WIDTH-1:0] pinIn_q,
   // Pads
   input wire logic [WIDTH-1:0] padIn,
   output logic [WIDTH-1:0] padOut,
   output logic [WIDTH-1:0] padOe,
   output logic [WIDTH-1:0] padPullup
);
   import pgm_pkg::*;

   // ---------------------------------------------------------------
   // State and decode
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] pinDirection_q;
   logic [WIDTH-1:0] pinOutputLatch_q;
   logic [WIDTH-1:0] pinPullupEnable_q;
   logic slaveMode;
   logic hwClear;
   logic wbReq;
   logic wbWrite;
   logic [15:0] regIdx;
   logic idxOk;
   pgm_pinfn_t pinFn;
   logic [WIDTH-1:0] portRead;
   logic [WIDTH-1:0] pinOeInt;
   logic [WIDTH-1:0] busOeSel;
   logic [WIDTH-1:0] busOutSel;
   logic busHold;

   // Slave enable only counts in single-chip mode
   assign slaveMode = dualPortSlaveEnable && (opMode == MODE_SINGLE); // RULE16 RULE6
   // Hardware standby acts like reset on the direction, latch and pull-up registers and the pin cells
   assign hwClear = hwStandby; // RULE8
   assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wbWrite = wbReq && wb_we_i && wb_sel_i[0];
   // Word index from the byte address; low two bits must be zero
   assign regIdx = wb_adr_i[ADDR_W-1:2];
   assign idxOk = (wb_adr_i[1:0] == 2'b00);

   // Pin function from mode and slave enable
   always_comb begin
      if (opMode == MODE_EXP1 || opMode == MODE_EXP2) begin
         pinFn = PFN_EXT_BUS; // RULE2
      end else if (slaveMode) begin
         pinFn = PFN_DPRAM; // RULE6
      end else begin
         pinFn = PFN_GPIO;
      end
   end

   // Bus drivers float in standby; reset is covered by the pin cell reset
   always_comb begin
      busHold = hwStandby || swStandby; // RULE3 RULE7
      if (pinFn == PFN_DPRAM) begin
         busOeSel = {WIDTH{dpBusOe}};
         busOutSel = dpBusOut;
      end else begin
         busOeSel = {WIDTH{extBusOe}};
         busOutSel = extBusOut;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Direction: cleared by reset, hardware standby and slave mode
   always_ff @(posedge sys_clk) begin
      if (!rstn || hwClear) begin
         pinDirection_q <= RST_DIR; // RULE5 RULE8
      end else if (slaveMode) begin
         pinDirection_q <= RST_DIR; // RULE6
      end else if (wbWrite && idxOk && regIdx == IDX_DIR) begin
         pinDirection_q <= wb_dat_i[WIDTH-1:0];
      end
   end

   // Output latch; software standby simply leaves it alone
   always_ff @(posedge sys_clk) begin
      if (!rstn || hwClear) begin
         pinOutputLatch_q <= RST_LATCH; // RULE10
      end else if (wbWrite && idxOk && regIdx == IDX_LATCH) begin
         pinOutputLatch_q <= wb_dat_i[WIDTH-1:0];
      end
   end

   // Pull-up control, readable and writable
   always_ff @(posedge sys_clk) begin
      if (!rstn || hwClear) begin
         pinPullupEnable_q <= RST_PULLUP; // RULE12
      end else if (wbWrite && idxOk && regIdx == IDX_PULLUP) begin
         pinPullupEnable_q <= wb_dat_i[WIDTH-1:0];
      end
   end

   // Sampled pin levels, visible to the bus masters outside
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pinIn_q <= '0;
      end else begin
         pinIn_q <= padIn;
      end
   end

   // Port read mixes latch and pin per direction bit
   assign portRead = (pinDirection_q & pinOutputLatch_q) | (~pinDirection_q & pinIn_q); // RULE9

   // ---------------------------------------------------------------
   // Wishbone slave: one wait-free answer one cycle after request
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wbReq;
      end
   end

   // Read data; unmapped indices read zero and still get ack
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wb_dat_o <= UNMAPPED_VAL;
      end else if (wbReq && !wb_we_i) begin
         wb_dat_o <= UNMAPPED_VAL;
         if (idxOk && regIdx == IDX_DIR) begin
            wb_dat_o[WIDTH-1:0] <= DIR_READ_VAL; // RULE1
         end else if (idxOk && regIdx == IDX_LATCH) begin
            wb_dat_o[WIDTH-1:0] <= portRead; // RULE9
         end else if (idxOk && regIdx == IDX_PULLUP) begin
            wb_dat_o[WIDTH-1:0] <= pinPullupEnable_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin cells
   // ---------------------------------------------------------------
   generate
      for (genvar i = 0; i < WIDTH; i++) begin : g_pin
         pgm_pin_cell u_cell (
            .sys_clk(sys_clk),
            .rstn(rstn && !hwStandby), // RULE13
            .pinFn(pinFn),
            .holdOff(busHold),
            .dirBit(pinDirection_q[i]),
            .pullBit(pinPullupEnable_q[i]),
            .busOe(busOeSel[i]),
            .busOut(busOutSel[i]),
            .latchBit(pinOutputLatch_q[i]),
            .pinOe_q(pinOeInt[i]),
            .pinOut_q(padOut[i]),
            .pinPull_q(padPullup[i])
         );
      end
   endgenerate
   assign padOe = pinOeInt;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // Mode and pin checks, all of them off while reset is held
   AST_DIR_READ_ONES: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE1
      (wbReq && !wb_we_i && idxOk && regIdx == IDX_DIR) |=> wb_dat_o[WIDTH-1:0] == DIR_READ_VAL)
      else $error("direction read not all ones");
   AST_EXT_BUS_FLOAT: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
      (pinFn == PFN_EXT_BUS && (hwStandby || swStandby)) |=> padOe == '0)
      else $error("external bus driven in standby");
   AST_GPIO_DRIVE: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
      (pinFn == PFN_GPIO && !hwStandby) |=> (padOe == $past(pinDirection_q)))
      else $error("gpio enable differs from direction");
   AST_HW_CLEAR: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE8
      hwStandby |=> (pinDirection_q == RST_DIR && pinOutputLatch_q == RST_LATCH
                     && pinPullupEnable_q == RST_PULLUP))
      else $error("hardware standby did not clear registers");
   AST_SLAVE_DIR: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE6
      slaveMode |=> pinDirection_q == RST_DIR)
      else $error("slave mode left direction set");
   AST_SW_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
      (swStandby && !hwStandby && !slaveMode && !wbWrite) |=> $stable(pinDirection_q))
      else $error("direction changed in software standby");
   AST_DP_FLOAT: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
      (pinFn == PFN_DPRAM && swStandby) |=> padOe == '0)
      else $error("dual-port bus driven in software standby");
   AST_PULL_OFF: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE13
      (pinFn != PFN_GPIO || hwStandby) |=> padPullup == '0)
      else $error("pull-up on outside gpio mode");
   AST_PULL_ON: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE11
      (pinFn == PFN_GPIO && !hwStandby) |=> padPullup == $past(~pinDirection_q & pinPullupEnable_q))
      else $error("pull-up mismatch");
   AST_ACK_ONE: assert property (@(posedge sys_clk) disable iff (!rstn)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

   // ---------------------------------------------------------------
   // Assertions: data paths and register contents
   // ---------------------------------------------------------------
   // Register selects for the checks below; standby of either kind
   // floats the shared buses
   logic chkDirSel;
   logic chkLatchSel;
   logic chkPullSel;
   logic chkStandby;
   assign chkDirSel = idxOk && (regIdx == IDX_DIR);
   assign chkLatchSel = idxOk && (regIdx == IDX_LATCH);
   assign chkPullSel = idxOk && (regIdx == IDX_PULLUP);
   assign chkStandby = hwStandby || swStandby;

   // Expanded modes: the pins follow the external bus drive, one cycle late
   AST_EXT_DRIVE: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2
      (pinFn == PFN_EXT_BUS && extBusOe && !chkStandby)
      |=> (padOe == '1 && padOut == $past(extBusOut)))
      else $error("external bus not driven onto pins");

   // Slave mode: the dual-port bus owns all pins while no standby is active
   AST_DP_DRIVE: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE6
      (pinFn == PFN_DPRAM && dpBusOe && !chkStandby)
      |=> (padOe == '1 && padOut == $past(dpBusOut)))
      else $error("dual-port bus not driven onto pins");

   // Plain GPIO: pad data is the output latch
   AST_GPIO_DATA: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
      (pinFn == PFN_GPIO && !hwStandby)
      |=> padOut == $past(pinOutputLatch_q))
      else $error("gpio pad data differs from latch");

   // Hardware standby floats every pin and drops every pull-up
   AST_HW_FLOAT: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
      hwStandby
      |=> (padOe == '0 && padPullup == '0))
      else $error("pin driven in hardware standby");

   // Reset is the event here, so this check has no disable
   AST_RESET_CLEAR: assert property (@(posedge sys_clk) // RULE8
      !rstn |=> (pinDirection_q == RST_DIR && pinOutputLatch_q == RST_LATCH
         && pinPullupEnable_q == RST_PULLUP && padOe == '0 && padPullup == '0))
      else $error("reset did not clear port state");

   // A direction write lands unless slave mode or hardware standby overrides it
   AST_DIR_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
      (wbWrite && chkDirSel && !slaveMode && !hwClear)
      |=> pinDirection_q == $past(wb_dat_i[WIDTH-1:0]))
      else $error("direction write lost");

   // A latch write lands in the cycle the slave takes it
   AST_LATCH_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
      (wbWrite && chkLatchSel && !hwClear)
      |=> pinOutputLatch_q == $past(wb_dat_i[WIDTH-1:0]))
      else $error("latch write lost");

   // Only a write or hardware standby may move the latch; software standby may not
   AST_LATCH_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE10
      (!hwClear && !(wbWrite && chkLatchSel))
      |=> $stable(pinOutputLatch_q))
      else $error("latch changed without a write");

   // Same for the pull-up control
   AST_PULL_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE12
      (!hwClear && !(wbWrite && chkPullSel))
      |=> $stable(pinPullupEnable_q))
      else $error("pull-up control changed without a write");

   // Port read: latch bits for outputs, sampled pins for inputs
   AST_PORT_READ: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
      (wbReq && !wb_we_i && chkLatchSel) |=> wb_dat_o[WIDTH-1:0]
         == $past((pinDirection_q & pinOutputLatch_q) | (~pinDirection_q & pinIn_q)))
      else $error("port read mixes latch and pins wrongly");

   // Pull-up control reads back as written
   AST_PULL_READ: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE12
      (wbReq && !wb_we_i && chkPullSel)
      |=> wb_dat_o[WIDTH-1:0] == $past(pinPullupEnable_q))
      else $error("pull-up control read back wrong");

   // Unused upper data bits read zero on every answer
   AST_READ_UPPER: assert property (@(posedge sys_clk) disable iff (!rstn)
      wb_ack_o
      |-> wb_dat_o[31:WIDTH] == '0)
      else $error("upper read data not zero");

   // One answer per request, in the next cycle
   AST_ACK_NEXT: assert property (@(posedge sys_clk) disable iff (!rstn)
      wbReq
      |=> wb_ack_o)
      else $error("request not answered in one cycle");

   // Main scenarios the run should pass through
   COV_GPIO_OUT: cover property (@(posedge sys_clk) pinFn == PFN_GPIO && padOe != '0);
   COV_SLAVE: cover property (@(posedge sys_clk) pinFn == PFN_DPRAM && padOe != '0);
   COV_EXT: cover property (@(posedge sys_clk) pinFn == PFN_EXT_BUS && swStandby);
   COV_PULL: cover property (@(posedge sys_clk) padPullup != '0);
   COV_SW_OUT: cover property (@(posedge sys_clk) pinFn == PFN_GPIO && swStandby && padOe != '0);
endmodule
`default_nettype wire

// ===== test_port3_gpio_bus_mux.sv
/*
 Self-checking bench for the shared pin port, with a Wishbone master.
 Assumes pgm_pkg, pgm_port3 and pgm_host_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_port3_gpio_bus_mux;
   import pgm_pkg::*;
   logic sys_clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [ADDR_W-1:0] adr = '0;
   logic [31:0] datI = '0, datO, rd;
   logic [1:0] opMode = MODE_SINGLE;
   logic dpse = 1'b0, hwSb = 1'b0, swSb = 1'b0, extOe = 1'b0, dpOe = 1'b0;
   logic [7:0] extOut = '0, dpOut = '0, hostOe = '0, hostData = '0;
   logic [7:0] pinIn, padIn, padOut, padOe, padPull, d, l, p, h;
   int miscompares = 0, n_compared = 0;
   // ---------------------------------------------------------------
   // Clock, design and far side
   // ---------------------------------------------------------------
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   pgm_port3 #(.WIDTH(8)) dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(datI),
      .wb_dat_o(datO), .wb_ack_o(ack), .opMode(opMode), .dualPortSlaveEnable(dpse),
      .hwStandby(hwSb), .swStandby(swSb), .extBusOe(extOe), .extBusOut(extOut),
      .dpBusOe(dpOe), .dpBusOut(dpOut), .pinIn_q(pinIn), .padIn(padIn),
      .padOut(padOut), .padOe(padOe), .padPullup(padPull));
   pgm_host_model host (.sys_clk(sys_clk), .padOut(padOut), .padOe(padOe),
      .padPullup(padPull), .hostOe(hostOe), .hostData(hostData), .padIn(padIn));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Classic cycle: request held until ack is sampled, then released
   task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] v);
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      datI <= {24'h0000_00, v};
      do begin
         @(posedge sys_clk);
      end while (ack !== 1'b1);
      rd = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rdc(input string what, input logic [15:0] idx, input logic [31:0] exp);
      wb(1'b0, idx, 8'h00);
      check(what, rd, exp);
   endtask
   task automatic settle;
      repeat (3) @(posedge sys_clk);
   endtask
   // Port read: latch for outputs, pin level for inputs
   function automatic logic [31:0] expRead(input logic [7:0] dv, lv, hv);
      return {24'h0000_00, (lv & dv) | (hv & ~dv)};
   endfunction
   task automatic conclude;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   // Generous bound; the sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      conclude;
   end
   initial begin
      void'($urandom(32'h4c86_3853));
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      hostOe <= 8'hff;
      hostData <= 8'ha5;
      settle;
      check("padOe", padOe, 0);
      rdc("pullup", IDX_PULLUP, 0);
      rdc("dir", IDX_DIR, {24'h0000_00, DIR_READ_VAL});
      rdc("latch", IDX_LATCH, 32'h0000_00a5);
      rdc("unmapped", 16'h0100, UNMAPPED_VAL);
      $display("test reset done");
      for (int i = 0; i < 20; i++) begin
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         l = 8'($urandom);
         p = 8'($urandom);
         h = 8'($urandom);
         wb(1'b1, IDX_DIR, 8'h00);
         wb(1'b1, IDX_PULLUP, p);
         wb(1'b1, IDX_DIR, d);
         wb(1'b1, IDX_LATCH, l);
         hostOe <= ~d;
         hostData <= h;
         settle;
         check("padOe", padOe, d);
         check("padOut", padOut & d, l & d);
         check("padPullup", padPull, ~d & p);
         check("pinIn", pinIn, (d & l) | (~d & h));
         rdc("dir", IDX_DIR, 32'h0000_00ff);
         rdc("pullup", IDX_PULLUP, p);
         rdc("latch", IDX_LATCH, expRead(d, l, h));
      end
      swSb <= 1'b1;
      settle;
      check("padOe", padOe, d);
      check("padPullup", padPull, ~d & p);
      rdc("latch", IDX_LATCH, expRead(d, l, h));
      swSb <= 1'b0;
      hwSb <= 1'b1;
      hostOe <= 8'h00;
      settle;
      check("padPullup", padPull, 0);
      hwSb <= 1'b0;
      settle;
      check("padOe", padOe, 0);
      rdc("pullup", IDX_PULLUP, 0);
      wb(1'b1, IDX_DIR, 8'hff);
      settle;
      check("padOut", padOut, 0);
      $display("test gpio done");
      h = 8'($urandom);
      wb(1'b1, IDX_PULLUP, 8'hff);
      wb(1'b1, IDX_LATCH, 8'h00);
      dpse <= 1'b1;
      dpOe <= 1'b1;
      dpOut <= h;
      settle;
      check("padOe", padOe, 8'hff);
      check("padOut", padOut, h);
      check("padPullup", padPull, 0);
      wb(1'b1, IDX_DIR, 8'hff);
      swSb <= 1'b1;
      settle;
      check("padOe", padOe, 0);
      swSb <= 1'b0;
      dpse <= 1'b0;
      dpOe <= 1'b0;
      settle;
      check("padOe", padOe, 0);
      check("padPullup", padPull, 8'hff);
      $display("test slave done");
      for (int k = 0; k < 2; k++) begin
         opMode <= (k == 1) ? MODE_EXP2 : MODE_EXP1;
         extOe <= 1'b0;
         settle;
         check("padPullup", padPull, 0);
         wb(1'b1, IDX_DIR, 8'hff);
         settle;
         check("padOe", padOe, 0);
         h = 8'($urandom);
         extOe <= 1'b1;
         extOut <= h;
         settle;
         check("padOe", padOe, 8'hff);
         check("padOut", padOut, h);
         swSb <= 1'b1;
         settle;
         check("padOe", padOe, 0);
         swSb <= 1'b0;
         wb(1'b1, IDX_DIR, 8'h00);
      end
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("padOe", padOe, 0);
      $display("test bus done");
      conclude;
   end
endmodule
`default_nettype wire
